// ### bsc_pkg.sv
// Shared constants and types for the burst static RAM controller
package bsc_pkg;
  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int CNT_LSB = 2;
  localparam int DEC_HI = 31;
  localparam int DEC_LO = 29;
  localparam logic [2:0] DEC_MATCH = 3'h0;
  localparam int BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Control state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BSC_IDLE = 3'h1,
    BSC_INSTR_ACCESS_STATE = 3'h2,
    BSC_DACCESS = 3'h4
  } bsc_state_t;
endpackage

// ### bsc_skid_buf.sv
// Two-entry buffer for read data on its way to the processor bus
`timescale 1ns/10ps
`default_nettype none
module bsc_skid_buf #(
  parameter int WIDTH = bsc_pkg::DATA_W,
  parameter int DEPTH = bsc_pkg::BUF_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  // Entry 0 drives the output, entry 1 catches a word during a stall
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] full;
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] next_full;
  logic take_in;
  logic give_out;
  logic room;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    take_in = i_valid && !full[DEPTH-1];
    give_out = full[0] && i_ready;
    next_mem = mem;
    next_full = full;
    if (give_out) begin
      // Shift the parked word forward so nothing is lost on a stall
      next_mem[0] = mem[1];
      next_full[0] = full[1];
      next_full[1] = 1'b0;
    end
    if (take_in) begin
      if (!next_full[0]) begin
        next_mem[0] = i_data;
        next_full[0] = 1'b1;
      end else begin
        next_mem[1] = i_data;
        next_full[1] = 1'b1;
      end
    end
  end

  // Registers only; ready is registered so it sees the drain only a cycle later
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      full <= '0;
      room <= 1'b1;
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= '0;
      end
    end else begin
      full <= next_full;
      room <= !next_full[DEPTH-1];
      mem <= next_mem;
    end
  end

  assign o_data = mem[0];
  assign o_valid = full[0];
  assign o_ready = room;
endmodule
`default_nettype wire

// ### bsc_ctrl.sv
// Burst static RAM controller: decode, state machine, address counter
`timescale 1ns/10ps
`default_nettype none
module bsc_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_instr_enable,
  input wire logic i_instr_request,
  input wire logic i_instr_burst_req,
  input wire logic i_data_request,
  input wire logic i_data_burst_req,
  input wire logic i_data_req_type0,
  input wire logic i_data_req_type1,
  input wire logic i_read_not_write,
  input wire logic [bsc_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_bus_invalid,
  input wire logic i_aux_select_pin,
  input wire logic [bsc_pkg::DATA_W-1:0] i_ram_rdata,
  input wire logic i_bus_rready,
  output logic [bsc_pkg::CNT_W-1:0] o_ram_addr,
  output logic o_instr_ready_resp,
  output logic o_data_ready_resp,
  output logic o_data_out_drive,
  output logic o_ram_write_en,
  output logic o_instr_burst_grant,
  output logic o_data_burst_grant,
  output logic o_count_advance,
  output logic o_ram_rready,
  output logic [bsc_pkg::DATA_W-1:0] o_bus_rdata,
  output logic o_bus_rvalid
);
  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  bsc_pkg::bsc_state_t state, next_state;
  logic instr_first_cycle, next_instr_first_cycle;
  logic data_first_cycle, next_data_first_cycle;
  logic instr_burst_req_q, data_burst_req_q, bus_invalid_q;
  logic [bsc_pkg::CNT_W-1:0] addr_cnt, next_addr_cnt;
  logic next_instr_ready_resp, next_data_ready_resp, next_doe, next_we, next_cnt_out, next_rd_push;
  logic rd_push;
  // Combinational decode
  logic instr_request, instr_burst_req, instr_mem_match, data_mem_match;
  logic instr_burst_grant, data_burst_grant, iexit, dexit;
  logic counter_load, count_advance, next_ig, next_dg;

  // Address decode is shared by both request paths
  function automatic logic addr_hits(input logic [bsc_pkg::ADDR_W-1:0] a, input logic aux);
    addr_hits = (a[bsc_pkg::DEC_HI:bsc_pkg::DEC_LO] == bsc_pkg::DEC_MATCH) && !aux;
  endfunction

  // ----------------------------------------------------------------
  // Decode, grants, load and count
  // ----------------------------------------------------------------
  always_comb begin
    instr_request = i_instr_request && i_instr_enable;
    instr_burst_req = i_instr_burst_req && i_instr_enable;
    instr_burst_grant = (state == bsc_pkg::BSC_INSTR_ACCESS_STATE);
    data_burst_grant = (state == bsc_pkg::BSC_DACCESS);
    instr_mem_match = instr_request && addr_hits(i_addr, i_aux_select_pin);
    data_mem_match = i_data_request && !i_data_req_type0 && !i_data_req_type1
      && addr_hits(i_addr, i_aux_select_pin);
    iexit = data_mem_match || (instr_request && !instr_mem_match);
    dexit = (instr_mem_match && !data_burst_req_q) || (i_data_request && !data_mem_match);
    // data match wins over an instruction burst
    next_ig = !data_burst_grant && instr_mem_match && !data_mem_match
      || !iexit && instr_burst_grant;
    next_dg = !instr_burst_grant && data_mem_match || !dexit && data_burst_grant;
    // first word one cycle after decode
    // a new grant begins only with a first-cycle flag
    next_instr_first_cycle = !data_burst_grant && instr_mem_match && !data_mem_match
      && !instr_first_cycle;
    next_data_first_cycle = !instr_burst_grant && data_mem_match && !data_first_cycle;
    // load for a new instruction or data access
    counter_load = (instr_request && !data_burst_grant && !instr_first_cycle)
      || (i_data_request && !instr_burst_grant && !data_first_cycle);
    // advance on registered burst request with grant
    count_advance = !bus_invalid_q && (instr_burst_req_q && instr_burst_grant
      || data_burst_req_q && data_burst_grant);
    // counter captures address at end of decode
    if (counter_load) begin
      next_addr_cnt = i_addr[bsc_pkg::CNT_LSB +: bsc_pkg::CNT_W];
    end else if (count_advance) begin
      next_addr_cnt = addr_cnt + 16'h0001;
    end else begin
      next_addr_cnt = addr_cnt;
    end
    if (next_ig) begin
      next_state = bsc_pkg::BSC_INSTR_ACCESS_STATE;
    end else if (next_dg) begin
      next_state = bsc_pkg::BSC_DACCESS;
    end else begin
      next_state = bsc_pkg::BSC_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Responses, computed from next register values so outputs are flops
  // ----------------------------------------------------------------
  always_comb begin
    // ready in the cycle after decode
    // ready follows the current burst request, not the registered one
    // resumes at once without a new decode
    next_instr_ready_resp = !i_bus_invalid && (next_instr_first_cycle
      || instr_burst_req && instr_burst_grant);
    // no burst request gives only the first-cycle word
    next_data_ready_resp = !i_bus_invalid && (next_data_first_cycle
      || i_data_burst_req && data_burst_grant);
    // drive and write enable mirror data ready
    next_doe = next_data_ready_resp && i_read_not_write;
    // writes use the data sequence with write enable
    next_we = next_data_ready_resp && !i_read_not_write;
    next_cnt_out = !i_bus_invalid && (instr_burst_req && next_ig || i_data_burst_req && next_dg);
    // Capture RAM data into the buffer on each read response
    next_rd_push = next_instr_ready_resp || next_doe;
  end

  // All state registers; synchronous active-low reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= bsc_pkg::BSC_IDLE;
      instr_first_cycle <= 1'b0;
      data_first_cycle <= 1'b0;
      instr_burst_req_q <= 1'b0;
      data_burst_req_q <= 1'b0;
      bus_invalid_q <= 1'b0;
      o_instr_burst_grant <= 1'b0;
      o_data_burst_grant <= 1'b0;
      addr_cnt <= bsc_pkg::CNT_RST;
      o_instr_ready_resp <= 1'b0;
      o_data_ready_resp <= 1'b0;
      o_data_out_drive <= 1'b0;
      o_ram_write_en <= 1'b0;
      o_count_advance <= 1'b0;
      rd_push <= 1'b0;
    end else begin
      state <= next_state;
      instr_first_cycle <= next_instr_first_cycle;
      data_first_cycle <= next_data_first_cycle;
      // burst request sampled at end of access's first cycle
      instr_burst_req_q <= instr_burst_req;
      data_burst_req_q <= i_data_burst_req;
      bus_invalid_q <= i_bus_invalid;
      // Grant pins copy the next state so they leave a flop, not a decode
      o_instr_burst_grant <= (next_state == bsc_pkg::BSC_INSTR_ACCESS_STATE);
      o_data_burst_grant <= (next_state == bsc_pkg::BSC_DACCESS);
      addr_cnt <= next_addr_cnt;
      o_instr_ready_resp <= next_instr_ready_resp;
      o_data_ready_resp <= next_data_ready_resp;
      o_data_out_drive <= next_doe;
      o_ram_write_en <= next_we;
      o_count_advance <= next_cnt_out;
      rd_push <= next_rd_push;
    end
  end

  assign o_ram_addr = addr_cnt;

  // ----------------------------------------------------------------
  // Read data buffer: holds two words for a stalled receiver; pushes while full are dropped
  // ----------------------------------------------------------------
  bsc_skid_buf u_rbuf (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_data(i_ram_rdata),
    .i_valid(rd_push),
    .o_ready(o_ram_rready),
    .o_data(o_bus_rdata),
    .o_valid(o_bus_rvalid),
    .i_ready(i_bus_rready)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  instr_load_a: assert property (instr_mem_match && !data_mem_match && state == bsc_pkg::BSC_IDLE
    && !instr_first_cycle |=> addr_cnt == 16'($past(i_addr) >> bsc_pkg::CNT_LSB))
    else $error("address not captured after instruction decode");
  first_ready_a: assert property (instr_first_cycle |-> o_instr_ready_resp == !bus_invalid_q)
    else $error("first instruction word missing ready");
  count_step_a: assert property (count_advance && !counter_load |=> addr_cnt == $past(addr_cnt) + 16'h0001)
    else $error("counter did not advance");
  suspend_hold_a: assert property (!counter_load && !count_advance |=> $stable(addr_cnt))
    else $error("address moved during suspension");
  resume_ready_a: assert property (instr_burst_grant && instr_burst_req_q && !bus_invalid_q
    |-> o_instr_ready_resp)
    else $error("ready missing while burst resumed");
  write_en_a: assert property (o_ram_write_en |-> o_data_ready_resp && !o_data_out_drive)
    else $error("write enable without data ready");
  preempt_a: assert property (instr_burst_grant && data_mem_match |=> !instr_burst_grant)
    else $error("instruction grant not dropped on preemption");
  preempt_load_a: assert property (instr_burst_grant && data_mem_match ##1 i_data_request
    |-> counter_load)
    else $error("no load for the pending data access");
  single_word_a: assert property (data_first_cycle && !data_burst_req_q |=> !o_data_ready_resp)
    else $error("extra word on single data access");
  invalid_block_a: assert property (bus_invalid_q |-> !o_data_out_drive && !o_ram_write_en)
    else $error("drive or write while bus invalid");
  data_match_a: assert property ($rose(o_data_burst_grant) |-> $past(i_data_request)
    && !$past(i_data_req_type0) && !$past(i_data_req_type1) && !$past(i_aux_select_pin))
    else $error("data grant without a clean data match");
  burst_cv: cover property ((instr_burst_grant && count_advance) [*3]);
  preempt_cv: cover property (instr_burst_grant ##1 data_burst_grant);
  stall_cv: cover property (o_bus_rvalid && !i_bus_rready && !o_ram_rready);
endmodule
`default_nettype wire

// ### bsc_far_model.sv
// Far-side model: memory array content and the read-data receiver
`timescale 1ns/10ps
`default_nettype none
module bsc_far_model (
  input wire logic [bsc_pkg::CNT_W-1:0] i_ram_addr,
  input wire logic i_stall,
  output logic [bsc_pkg::DATA_W-1:0] o_ram_rdata,
  output logic o_bus_rready
);
  // ----------------------------------------------------------------
  // Memory and receiver
  // ----------------------------------------------------------------
  // Content tracks the address, so a stuck counter shows as a repeated word
  assign o_ram_rdata = {16'hC3C3, i_ram_addr};
  // Receiver stalls on command, which lets the buffer fill up
  assign o_bus_rready = ~i_stall;
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the burst static RAM controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clk, i_rst_b, i_instr_enable, i_instr_request, i_instr_burst_req, i_data_request;
  logic i_data_burst_req, i_data_req_type0, i_data_req_type1, i_read_not_write, i_bus_invalid;
  logic i_aux_select_pin, i_bus_rready, stall, o_instr_ready_resp, o_data_ready_resp;
  logic o_data_out_drive, o_ram_write_en, o_instr_burst_grant, o_data_burst_grant;
  logic o_count_advance, o_ram_rready, o_bus_rvalid;
  logic [bsc_pkg::ADDR_W-1:0] i_addr;
  logic [bsc_pkg::DATA_W-1:0] i_ram_rdata, o_bus_rdata;
  logic [bsc_pkg::CNT_W-1:0] o_ram_addr;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  bsc_ctrl dut (.i_clk, .i_rst_b, .i_instr_enable, .i_instr_request, .i_instr_burst_req,
    .i_data_request, .i_data_burst_req, .i_data_req_type0, .i_data_req_type1, .i_read_not_write,
    .i_addr, .i_bus_invalid, .i_aux_select_pin, .i_ram_rdata, .i_bus_rready, .o_ram_addr,
    .o_instr_ready_resp, .o_data_ready_resp, .o_data_out_drive, .o_ram_write_en,
    .o_instr_burst_grant, .o_data_burst_grant, .o_count_advance, .o_ram_rready, .o_bus_rdata,
    .o_bus_rvalid);
  bsc_far_model far (.i_ram_addr(o_ram_addr), .i_stall(stall), .o_ram_rdata(i_ram_rdata),
    .o_bus_rready(i_bus_rready));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Inputs move 1 ns after the edge so the design never samples a race
  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset;
    {i_instr_request, i_instr_burst_req, i_data_request, i_data_burst_req} = 4'h0;
    {i_data_req_type0, i_data_req_type1, i_bus_invalid, i_aux_select_pin, stall} = 5'h00;
    i_instr_enable = 1'b1;
    i_read_not_write = 1'b1;
    i_addr = 32'h0000_0000;
    i_rst_b = 1'b0;
    step(3);
    i_rst_b = 1'b1;
    step;
    chk("grant after reset", 0, o_instr_burst_grant);
    chk("addr after reset", 0, o_ram_addr);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Instruction burst with a one-cycle suspension in mid-run
  task automatic t_burst;
    do_reset;
    {i_instr_request, i_instr_burst_req} = 2'h3;
    i_addr = 32'h0000_0040;
    step;
    chk("first ready", 1, o_instr_ready_resp);
    chk("loaded addr", 16'h0010, o_ram_addr);
    chk("instr grant", 1, o_instr_burst_grant);
    chk("count on", 1, o_count_advance);
    step;
    i_instr_request = 1'b0;
    chk("second ready", 1, o_instr_ready_resp);
    chk("counted addr", 16'h0011, o_ram_addr);
    i_instr_burst_req = 1'b0;
    step;
    chk("suspend ready", 0, o_instr_ready_resp);
    chk("count off", 0, o_count_advance);
    i_instr_burst_req = 1'b1;
    step;
    chk("resume ready", 1, o_instr_ready_resp);
    chk("held addr", 16'h0012, o_ram_addr);
    chk("count back", 1, o_count_advance);
    step;
    chk("resumed count", 16'h0013, o_ram_addr);
  endtask
  // Data read preempts an instruction burst, which is then restarted
  task automatic t_preempt;
    int n;
    do_reset;
    {i_instr_request, i_instr_burst_req} = 2'h3;
    i_addr = 32'h0000_0040;
    step(2);
    i_instr_request = 1'b0;
    i_data_request = 1'b1;
    i_addr = 32'h0000_0100;
    step;
    chk("last instr word", 1, o_instr_ready_resp);
    chk("grant withdrawn", 0, o_instr_burst_grant);
    i_instr_burst_req = 1'b0;
    step;
    chk("single data ready", 1, o_data_ready_resp);
    chk("read drive", 1, o_data_out_drive);
    chk("data addr", 16'h0040, o_ram_addr);
    chk("data grant", 1, o_data_burst_grant);
    // Request stands through its ready cycle, as the processor only sees ready at its end
    step;
    chk("no second word", 0, o_data_ready_resp);
    // data dropped after its ready, instruction reissued
    i_data_request = 1'b0;
    {i_instr_request, i_instr_burst_req} = 2'h3;
    i_addr = 32'h0000_0040;
    n = 0;
    while (o_instr_ready_resp !== 1'b1 && n < 6) begin
      step;
      n++;
    end
    i_instr_request = 1'b0;
    chk("restart cycles", 2, n);
    chk("restart grant", 1, o_instr_burst_grant);
    chk("restart addr", 16'h0010, o_ram_addr);
    chk("restart count", 1, o_count_advance);
  endtask
  // Two-word data burst write
  task automatic t_write;
    do_reset;
    {i_data_request, i_data_burst_req, i_read_not_write} = 3'h6;
    i_addr = 32'h0000_0200;
    step;
    chk("write enable 1", 1, o_ram_write_en);
    chk("no drive on write", 0, o_data_out_drive);
    chk("write addr", 16'h0080, o_ram_addr);
    chk("write grant", 1, o_data_burst_grant);
    i_data_request = 1'b0;
    step;
    chk("write enable 2", 1, o_ram_write_en);
    chk("write addr 2", 16'h0081, o_ram_addr);
    i_data_burst_req = 1'b0;
    step;
    chk("write ends", 0, o_ram_write_en);
  endtask
  // Requests that must not be answered: types, aux pin, decode, invalid, data-only use
  task automatic t_refuse;
    for (int k = 0; k < 6; k++) begin
      do_reset;
      i_data_request = (k != 5);
      {i_instr_request, i_instr_enable} = {k == 5, k != 5};
      {i_data_req_type0, i_data_req_type1, i_aux_select_pin} = {k == 0, k == 1, k == 2};
      i_addr = (k == 3) ? 32'h2000_0100 : 32'h0000_0100;
      i_bus_invalid = (k == 4);
      step;
      chk("refused data", 0, o_data_ready_resp);
      chk("refused instr", 0, o_instr_ready_resp);
      chk("refused drive", 0, o_data_out_drive);
    end
  endtask
  // Read burst into a stalled receiver, then drain the buffer
  task automatic t_buffer;
    int got;
    do_reset;
    stall = 1'b1;
    {i_data_request, i_data_burst_req} = 2'h3;
    i_addr = 32'h0000_0080;
    step(2);
    {i_data_request, i_data_burst_req} = 2'h0;
    step(3);
    chk("buffer full", 0, o_ram_rready);
    chk("buffer valid", 1, o_bus_rvalid);
    stall = 1'b0;
    got = 0;
    repeat (6) begin
      if (o_bus_rvalid === 1'b1) begin
        chk("buffered word", {16'hC3C3, 16'h0020 + 16'(got)}, o_bus_rdata);
        got++;
      end
      step;
    end
    chk("words drained", 2, got);
    chk("buffer empty", 0, o_bus_rvalid);
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Whole run needs about 80 cycles; 3000 means a hang
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    do_reset;
    t_burst;
    t_preempt;
    t_write;
    t_refuse;
    t_buffer;
    close_out;
  end
endmodule
`default_nettype wire
